// *** inc/rbs_pkg.sv ***
package rbs_pkg;

    // register map, byte addresses on the apb side
    localparam int         APB_AW     = 8;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CAUSE  = 8'h08;

    // control register fields
    localparam int   CTRL_SWEN     = 0;
    localparam logic CTRL_SWEN_RST = 1'b0;

    // status register fields, all read only
    localparam int STB_READY  = 0;
    localparam int STB_BELOW  = 1;
    localparam int STB_CORE   = 2;
    localparam int STB_ACTIVE = 3;
    localparam int STB_WAKE   = 4;
    localparam int STB_PIN_EN = 5;

    // reset cause flags: low means that cause happened, stack flags are high
    localparam int         CAUSE_W   = 7;
    localparam int         C_POR     = 0;
    localparam int         C_BOR     = 1;
    localparam int         C_PIN     = 2;
    localparam int         C_WDT     = 3;
    localparam int         C_RI      = 4;
    localparam int         C_STKO    = 5;
    localparam int         C_STKU    = 6;
    localparam logic [6:0] CAUSE_RST = 7'h1f;

    // brown-out modes and power-up timer selection
    localparam logic [1:0] BM_OFF     = 2'h0;
    localparam logic [1:0] BM_SW      = 2'h1;
    localparam logic [1:0] BM_NOSLEEP = 2'h2;
    localparam logic [1:0] BM_ON      = 2'h3;
    localparam logic [1:0] POWERUP_DELAY_TIMER_OFF   = 2'h0;
    localparam logic [1:0] POWERUP_DELAY_TIMER_QTR   = 2'h2;

    // timing: 40 mhz system clock
    localparam int CLK_NS       = 25;
    localparam int POWERUP_DELAY_TIMER_MS      = 64;
    localparam int POWERUP_DELAY_TIMER_CYC     = POWERUP_DELAY_TIMER_MS * 1000000 / CLK_NS;
    localparam int BOR_DBNC_NS  = 1000;
    localparam int BOR_DBNC_CYC = (BOR_DBNC_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXEC_DLY_CYC = 10;

    typedef enum logic [2:0] {
        ST_POR, ST_BWAIT, ST_POWERUP_DELAY_TIMER, ST_PIN, ST_DELAY, ST_RUN
    } rbs_state_e;

endpackage : rbs_pkg

// *** design/rbs_filter.sv ***
// passes a high level only once it has stood longer than n cycles
module rbs_filter #(
    parameter int N = 40
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    import rbs_pkg::*;

    localparam int CW = $clog2(N + 1);

    if (N < 1) begin : g_bad_n
        $error("rbs_filter: N must be at least one");
    end

    logic [CW-1:0] cnt;
    wire           full = (cnt == CW'(N));

    // any low sample restarts the interval, so glitches never pass
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '0;
            dout <= 1'b0;
        end else begin
            cnt  <= !din ? '0 : (full ? cnt : CW'(cnt + 1'b1));
            dout <= din && full;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_FILT_LOW: assert property (!din |=> !dout)
        else $error("filter passed a low input");
    AST_FILT_LEN: assert property ($rose(dout) |-> $past(cnt) == CW'(N))
        else $error("filter output rose before the debounce interval");
endmodule : rbs_filter

// *** design/rbs_timer.sv ***
// power-up delay counter, loaded by a start pulse, done at zero
module rbs_timer #(
    parameter int CYC = 2560000
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic [1:0] sel,
    output logic            done
);
    import rbs_pkg::*;

    localparam int TW = $clog2(CYC + 1);

    if (CYC < 16) begin : g_bad_cyc
        $error("rbs_timer: CYC must be at least sixteen");
    end

    // selection 00 gives no delay at all, the others scale the full time
    function automatic logic [TW-1:0] len(input logic [1:0] s);
        if (s == POWERUP_DELAY_TIMER_OFF) return '0;
        else if (s == BM_ON) return TW'(CYC);
        else if (s == POWERUP_DELAY_TIMER_QTR) return TW'(CYC / 4);
        else return TW'(CYC / 16);
    endfunction : len

    logic [TW-1:0] cnt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (start) begin
            cnt <= len(sel);
        end else if (cnt != '0) begin
            cnt <= TW'(cnt - 1'b1);
        end
    end

    assign done = (cnt == '0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_TMR_RUN: assert property (start && sel != POWERUP_DELAY_TIMER_OFF |=> !done)
        else $error("power-up timer did not start");
endmodule : rbs_timer

// *** design/rbs_sequencer.sv ***
// Function
// - Eight reset sources: power-on, brown-out, pin, watchdog, instruction, stack, programming.
// - Leaving programming mode acts exactly like a power-on reset, flags included.
// - Enabled power-up timer lengthens the hold after power-on or brown-out.
// - Core stays in reset while power-on detector reports supply too low.
// - Start-up release also waits on power-up timer, brown-out readiness in modes 11 and 10, held pin.
// - Reset holds while brown-out detector reports supply below selected threshold.
// - Brown-out below threshold past the debounce interval resets and clears its flag.
// - Mode 11: detector always on; start-up waits for ready and supply above threshold.
// - Mode 11: protection stays on in sleep, wake-up not delayed.
// - Mode 10: detector on while awake, hibernates in sleep without protection.
// - Mode 10: wake-up waits for ready flag and supply above threshold.
// - Mode 01: software enable bit selects active (1) or hibernate (0).
// - Mode 01: start-up waits neither on readiness nor on supply level.
// - Mode 01: protection starts once ready; ready status bit is readable.
// - Mode 01: sleep entry or exit leaves protection unchanged.
// - Mode 00: detection always off, software enable writes ignored.
// - Mode 11: ready flag is already set when the core starts executing.
// - Power-up delay applies only when the timer select field is not 00.
// - Pin reset enabled by low-voltage programming or its enable bit.
// - With pin reset enabled, a low pin holds the device in reset.
// - Power-up timer starts after power-on and brown-out release, up to 64 ms.
// - Execution begins ten oscillator cycles after pin release and timer expiry.
module rbs_sequencer #(
    parameter int POWERUP_DELAY_TIMER_CYCLES     = rbs_pkg::POWERUP_DELAY_TIMER_CYC,
    parameter int BOR_DBNC_CYCLES = rbs_pkg::BOR_DBNC_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // apb register port
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [rbs_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // analog monitors and pin, asynchronous
    input  wire logic                        por_low,
    input  wire logic                        bor_below,
    input  wire logic                        bor_ready,
    input  wire logic                        external_reset_pin_n,
    // core events, same clock
    input  wire logic                        prog_mode_exit,
    input  wire logic                        wdt_timeout,
    input  wire logic                        reset_instr,
    input  wire logic                        stack_overflow,
    input  wire logic                        stack_underflow,
    input  wire logic                        sleep_mode,
    // configuration fields
    input  wire logic [1:0]                  brownout_mode_select,
    input  wire logic [1:0]                  brownout_threshold_select,
    input  wire logic [1:0]                  powerup_timer_select,
    input  wire logic                        external_reset_pin_enable,
    input  wire logic                        low_voltage_program_enable,
    // to core and analog
    output logic                             core_reset,
    output logic                             brownout_active,
    output logic                             brownout_hibernate,
    output logic      [1:0]                  brownout_threshold_voltage,
    output logic                             brownout_ready_flag,
    output logic                             wake_hold
);
    import rbs_pkg::*;

    localparam int DW = $clog2(EXEC_DLY_CYC + 1);

    if (POWERUP_DELAY_TIMER_CYCLES < 16 || BOR_DBNC_CYCLES < 1) begin : g_bad_param
        $error("rbs_sequencer: timing parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [3:0] sync_a;
    logic [3:0] sync_b;
    wire  [3:0] raw_in = {por_low, bor_below, bor_ready, ~external_reset_pin_n};

    // analog levels and the pin are asynchronous to clk
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire por_s     = sync_b[3];
    wire below_s   = sync_b[2];
    wire rdy_s     = sync_b[1];
    wire pin_low_s = sync_b[0];

    ////////////////////////////////////////////////////////////////////////////
    // brown-out mode decode

    logic sw_en;
    logic below_f;

    wire m_off     = (brownout_mode_select == BM_OFF);
    wire m_sw      = (brownout_mode_select == BM_SW);
    wire m_nosleep = (brownout_mode_select == BM_NOSLEEP);
    wire m_on      = (brownout_mode_select == BM_ON);

    // detector state per mode; mode 01 ignores sleep entirely
    wire det_on = m_on
                | (m_nosleep && !sleep_mode)
                | (m_sw && sw_en);
    wire det_hib = (m_nosleep && sleep_mode) | (m_sw && !sw_en);

    // the filter sees the raw comparator so its interval is not gated
    rbs_filter #(
        .N    (BOR_DBNC_CYCLES)
    ) u_filt (
        .clk  (clk),
        .nrst (nrst),
        .din  (below_s),
        .dout (below_f)
    );

    // protection only once the detector is ready and switched on
    wire bor_evt = det_on && rdy_s && below_f;

    ////////////////////////////////////////////////////////////////////////////
    // reset sources

    wire por_hold = por_s || prog_mode_exit;
    wire pin_en   = low_voltage_program_enable || external_reset_pin_enable;
    wire pin_hold = pin_en && pin_low_s;
    wire warm_evt = wdt_timeout || reset_instr
                 || stack_overflow || stack_underflow;

    // modes 11 and 10 hold start-up for ready and supply above threshold
    wire start_wait = m_on || m_nosleep;
    wire bwait_ok   = !start_wait || (rdy_s && !below_s);

    ////////////////////////////////////////////////////////////////////////////
    // start-up sequence

    rbs_state_e st;
    rbs_state_e next_st;
    logic [DW-1:0] dly_cnt;
    logic tmr_done;

    wire dly_last  = (dly_cnt == DW'(EXEC_DLY_CYC - 1));
    wire tmr_start = (next_st == ST_POWERUP_DELAY_TIMER) && (st != ST_POWERUP_DELAY_TIMER);

    // cold resets pre-empt everything; the order is the sequence itself
    always_comb begin
        next_st = st;
        if (por_hold) begin
            next_st = ST_POR;
        end else if (bor_evt) begin
            next_st = ST_BWAIT;
        end else begin
            case (st)
                ST_POR: next_st = ST_BWAIT;
                ST_BWAIT: if (bwait_ok) next_st = ST_POWERUP_DELAY_TIMER;
                ST_POWERUP_DELAY_TIMER: if (tmr_done) next_st = ST_PIN;
                ST_PIN: if (!pin_hold) next_st = ST_DELAY;
                ST_DELAY: begin
                    if (pin_hold || warm_evt) next_st = ST_PIN;
                    else if (dly_last) next_st = ST_RUN;
                end
                ST_RUN: if (pin_hold || warm_evt) next_st = ST_PIN;
                default: next_st = ST_POR;
            endcase
        end
    end

    // the timer counts only after the cold reset releases
    rbs_timer #(
        .CYC   (POWERUP_DELAY_TIMER_CYCLES)
    ) u_tmr (
        .clk   (clk),
        .nrst  (nrst),
        .start (tmr_start),
        .sel   (powerup_timer_select),
        .done  (tmr_done)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= ST_POR;
        end else begin
            st <= next_st;
        end
    end

    // ten cycle gap before the core may fetch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dly_cnt <= '0;
        end else if (st != ST_DELAY || next_st != ST_DELAY) begin
            dly_cnt <= '0;
        end else begin
            dly_cnt <= DW'(dly_cnt + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake-up hold in mode 10

    logic wake_pend;
    wire  wake_ok   = !sleep_mode && rdy_s && !below_s;
    // set wins: sleep in mode 10 keeps the hold armed
    wire  next_wake = (m_nosleep && sleep_mode)
                   || (wake_pend && m_nosleep && !wake_ok);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_pend <= 1'b0;
        end else begin
            wake_pend <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all registered

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_reset                 <= 1'b1;
            brownout_active            <= 1'b0;
            brownout_hibernate         <= 1'b0;
            brownout_threshold_voltage <= '0;
            brownout_ready_flag        <= 1'b0;
            wake_hold                  <= 1'b0;
        end else begin
            core_reset                 <= (next_st != ST_RUN);
            brownout_active            <= det_on;
            brownout_hibernate         <= det_hib;
            brownout_threshold_voltage <= brownout_threshold_select;
            brownout_ready_flag        <= det_on && rdy_s;
            wake_hold                  <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] next_cause;
    logic [31:0]        status_v;

    wire acc      = psel && penable;
    wire acc_done = acc && pready;
    wire hit_ctrl = (paddr == OFF_CTRL);
    wire hit_stat = (paddr == OFF_STATUS);
    wire hit_caus = (paddr == OFF_CAUSE);
    wire mapped   = hit_ctrl || hit_stat || hit_caus;
    wire wr_ctrl  = acc_done && pwrite && hit_ctrl;
    wire wr_caus  = acc_done && pwrite && hit_caus;

    wire [31:0] rdata = hit_ctrl ? 32'(sw_en) << CTRL_SWEN
                      : hit_stat ? status_v
                      : hit_caus ? 32'(cause)
                      : '0;

    always_comb begin
        status_v             = '0;
        status_v[STB_READY]  = brownout_ready_flag;
        status_v[STB_BELOW]  = below_f;
        status_v[STB_CORE]   = core_reset;
        status_v[STB_ACTIVE] = brownout_active;
        status_v[STB_WAKE]   = wake_hold;
        status_v[STB_PIN_EN] = pin_en;
    end

    // mode 00 locks the enable so a stale write cannot arm the detector
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_en <= CTRL_SWEN_RST;
        end else if (wr_ctrl && !m_off) begin
            sw_en <= pwdata[CTRL_SWEN];
        end
    end

    // software may rewrite flags, but a cause in the same cycle wins
    always_comb begin
        next_cause = wr_caus ? pwdata[CAUSE_W-1:0] : cause;
        if (por_hold || bor_evt) begin
            next_cause[C_STKO] = 1'b0;
            next_cause[C_STKU] = 1'b0;
            next_cause[C_PIN]  = 1'b1;
            next_cause[C_RI]   = 1'b1;
        end
        if (por_hold) begin
            next_cause[C_POR] = 1'b0;
            next_cause[C_WDT] = 1'b1;
        end
        if (bor_evt) next_cause[C_BOR] = 1'b0;
        if (pin_hold && st == ST_RUN) next_cause[C_PIN] = 1'b0;
        if (wdt_timeout) next_cause[C_WDT] = 1'b0;
        if (reset_instr) next_cause[C_RI] = 1'b0;
        if (stack_overflow) next_cause[C_STKO] = 1'b1;
        if (stack_underflow) next_cause[C_STKU] = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cause <= CAUSE_RST;
        end else begin
            cause <= next_cause;
        end
    end

    // answers in the second access cycle; unmapped reads zero with error
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            prdata  <= (acc && !pready && !pwrite) ? rdata : '0;
            pslverr <= acc && !pready && !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_POR_HOLD: assert property (por_s |=> core_reset)
        else $error("core left reset while power-on detector low");
    AST_PIN_HOLD: assert property (pin_hold |=> core_reset ##1 core_reset)
        else $error("core left reset while pin held low");
    AST_BOR_HOLD: assert property (bor_evt |=> core_reset && !cause[C_BOR])
        else $error("brown-out did not reset or clear its flag");
    AST_MODE_OFF: assert property (m_off |=> !brownout_active)
        else $error("detector active in mode 00");
    AST_MODE_ON: assert property (m_on |=> brownout_active && !brownout_hibernate)
        else $error("detector not active in mode 11");
    AST_SLEEP_HIB: assert property (m_nosleep && sleep_mode |=> brownout_hibernate)
        else $error("detector not hibernating in sleep, mode 10");
    AST_WAKE_WAIT: assert property (m_nosleep && sleep_mode |=> wake_hold)
        else $error("wake-up hold missing in mode 10");
    AST_WAKE_NONE: assert property (!m_nosleep |=> !wake_hold)
        else $error("wake-up held outside mode 10");
    AST_SW_NOWAIT: assert property (m_sw && st == ST_BWAIT && !bor_evt && !por_hold
                                    |=> st != ST_BWAIT)
        else $error("mode 01 start-up waited on the detector");
    AST_POWERUP_DELAY_TIMER_OFF: assert property (st == ST_POWERUP_DELAY_TIMER && powerup_timer_select == POWERUP_DELAY_TIMER_OFF
                                   && !por_hold && !bor_evt |=> st == ST_PIN)
        else $error("power-up delay applied with select 00");
    AST_EXEC_DLY: assert property ($fell(core_reset) |-> $past(st == ST_DELAY, 10))
        else $error("execution began without the ten cycle gap");
    AST_READY_ON: assert property ($fell(core_reset) && m_on |-> brownout_ready_flag)
        else $error("core started before ready flag in mode 11");
endmodule : rbs_sequencer

// *** test/rbs_supply_model.sv ***
// supply monitors and reset pin as the block sees them from outside
module rbs_supply_model #(
    parameter int READY_CYC = 8
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic supply_low,
    input  wire logic dip,
    input  wire logic pin_hold,
    input  wire logic active,
    output logic      por_low,
    output logic      bor_below,
    output logic      bor_ready,
    output logic      external_reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // the detector needs settling time after each switch-on, so ready lags active
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cnt <= 0;
        else if (!active) cnt <= 0;
        else if (cnt < READY_CYC) cnt <= cnt + 1;
    end
    assign bor_ready            = active && (cnt == READY_CYC);
    assign por_low              = supply_low;
    assign bor_below            = supply_low | dip;
    // weak pull-up: a released pin reads high
    assign external_reset_pin_n = !pin_hold;
endmodule : rbs_supply_model

// *** test/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rbs_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, sup_low = 1, dip = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, w;
    logic pready, pslverr, err, por_low, bor_below, bor_ready, pin_n, pin_hold = 0;
    logic prog_exit = 0, sleep = 0, pin_en = 1, lv_prog = 0, core_reset, act, hib, rdy, wake;
    logic [3:0] ev = 4'h0;
    logic [1:0] mode = BM_ON, thr = 2'h0, pup_sel = POWERUP_DELAY_TIMER_OFF, thr_out;
    int error_cnt = 0, compares = 0, cyc = 0, n;
    always #12.5 clk = ~clk;
    rbs_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(64), .BOR_DBNC_CYCLES(3)) u_dut (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_low(por_low),
        .bor_below(bor_below), .bor_ready(bor_ready), .external_reset_pin_n(pin_n),
        .prog_mode_exit(prog_exit), .wdt_timeout(ev[0]), .reset_instr(ev[1]),
        .stack_overflow(ev[2]), .stack_underflow(ev[3]), .sleep_mode(sleep),
        .brownout_mode_select(mode), .brownout_threshold_select(thr),
        .powerup_timer_select(pup_sel), .external_reset_pin_enable(pin_en),
        .low_voltage_program_enable(lv_prog), .core_reset(core_reset),
        .brownout_active(act), .brownout_hibernate(hib), .brownout_threshold_voltage(thr_out),
        .brownout_ready_flag(rdy), .wake_hold(wake));
    rbs_supply_model #(.READY_CYC(8)) u_model (.clk(clk), .nrst(nrst), .supply_low(sup_low),
        .dip(dip), .pin_hold(pin_hold), .active(act), .por_low(por_low),
        .bor_below(bor_below), .bor_ready(bor_ready), .external_reset_pin_n(pin_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // no local limit: only the hang guard may end this wait
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // the slave inserts exactly one wait state
        chk("apb_wait", k, 32'd2);
    endtask : apb
    // counts edges until core_reset shows v, bounded by lim
    task automatic wait_cr(input logic v, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (core_reset !== v && n < lim);
        chk("core_reset_wait", core_reset, v);
    endtask : wait_cr
    // cause bit left by each warm event: wdt, instr, overflow, underflow
    function automatic int ev_bit(input int k);
        return (k == 0) ? C_WDT : (k == 1) ? C_RI : (k == 2) ? C_STKO : C_STKU;
    endfunction : ev_bit
    task automatic pulse_ev(input logic [3:0] e, input logic pe, input int lim);
        @(posedge clk);
        ev        <= e;
        prog_exit <= pe;
        @(posedge clk);
        ev        <= 4'h0;
        prog_exit <= 1'b0;
        wait_cr(1'b0, lim);
    endtask : pulse_ev
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'h4ed6));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("por_hold", core_reset, 1);
        @(posedge clk);
        sup_low <= 1'b0;
        wait_cr(1'b0, 300);
        chk("ready_at_start", rdy, 1);
        chk("waited_ready", n > 8, 1);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk("por_cause", rd[C_POR], 0);
        for (int i = 0; i < 4; i++) begin
            thr <= 2'($urandom);
            repeat (3) @(posedge clk);
            chk("threshold", thr_out, thr);
        end
        // pin release to first instruction
        pin_hold <= 1'b1;
        wait_cr(1'b1, 10);
        chk("pin_hold", core_reset, 1);
        @(posedge clk);
        pin_hold <= 1'b0;
        wait_cr(1'b0, 40);
        chk("exec_delay", n, 13);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk("pin_cause", rd[C_PIN], 0);
        pin_en <= 1'b0;
        pin_hold <= 1'b1;
        repeat (10) @(posedge clk);
        chk("pin_off", core_reset, 0);
        lv_prog <= 1'b1;
        wait_cr(1'b1, 10);
        chk("pin_lv", core_reset, 1);
        lv_prog  <= 1'b0;
        pin_en   <= 1'b1;
        pin_hold <= 1'b0;
        wait_cr(1'b0, 40);
        for (int k = 0; k < 4; k++) begin
            pulse_ev(4'h1 << k, 1'b0, 40);
            apb(1'b0, OFF_CAUSE, 32'h0);
            chk("warm_cause", rd[ev_bit(k)], k > 1);
        end
        apb(1'b1, 8'h0c, 32'h1);
        chk("unmapped", err, 1);
        apb(1'b1, OFF_CAUSE, 32'h1f);
        pulse_ev(4'h0, 1'b1, 300);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk("prog_exit", rd[6:0], 7'h1e);
        pup_sel <= 2'h3;
        pulse_ev(4'h0, 1'b1, 300);
        chk("timer_full", n >= 74, 1);
        pup_sel <= POWERUP_DELAY_TIMER_OFF;
        pulse_ev(4'h0, 1'b1, 300);
        chk("timer_off", n < 64, 1);
        // short dip must be filtered, long dip resets
        dip <= 1'b1;
        repeat (2) @(posedge clk);
        dip <= 1'b0;
        repeat (8) @(posedge clk);
        chk("short_dip", core_reset, 0);
        sleep <= 1'b1;
        dip <= 1'b1;
        wait_cr(1'b1, 12);
        chk("dip_in_sleep", core_reset, 1);
        chk("no_wake_hold", wake, 0);
        dip   <= 1'b0;
        sleep <= 1'b0;
        wait_cr(1'b0, 300);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk("bor_cause", rd[C_BOR], 0);
        mode  <= BM_NOSLEEP;
        sleep <= 1'b1;
        repeat (5) @(posedge clk);
        chk("hib_sleep", {hib, wake}, 2'h3);
        dip <= 1'b1;
        repeat (10) @(posedge clk);
        chk("no_protect", core_reset, 0);
        dip   <= 1'b0;
        sleep <= 1'b0;
        n = 0;
        while (wake !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
            #1;
        end
        chk("wake_after_ready", {wake, rdy}, 2'h1);
        mode <= BM_OFF;
        apb(1'b1, OFF_CTRL, 32'h1);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("off_ctrl", {rd[0], act}, 2'h0);
        mode <= BM_SW;
        for (int i = 0; i < 4; i++) begin
            w = $urandom ^ 32'(i);
            apb(1'b1, OFF_CTRL, w);
            apb(1'b0, OFF_CTRL, 32'h0);
            chk("sw_readback", rd[CTRL_SWEN], w[CTRL_SWEN]);
            repeat (12) @(posedge clk);
            chk("sw_act", {act, hib}, {w[CTRL_SWEN], ~w[CTRL_SWEN]});
        end
        apb(1'b1, OFF_CTRL, 32'h1);
        repeat (14) @(posedge clk);
        sleep <= 1'b1;
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("sw_ready", rd[STB_READY], 1);
        chk("stat", rd, 32'h1 << STB_READY | 32'h1 << STB_ACTIVE | 32'h1 << STB_PIN_EN);
        chk("sw_sleep", act, 1);
        sleep <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h0);
        pulse_ev(4'h0, 1'b1, 80);
        chk("sw_start", {core_reset, rdy}, 2'h0);
        end_sim();
    end
endmodule : testbench
